// File: core/loop_regs_defs.svh
// Offsets, field positions, reset values and limits of the loop status bank
`ifndef LOOP_REGS_DEFS_SVH
`define LOOP_REGS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_DAMPING      12'h159
`define OFF_PAGE_SEL     12'h17F
`define OFF_STATUS       12'h180
`define OFF_FB_CTRL      12'h181
`define OFF_IRQ_MASK     12'h1F0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_DAMPING      4'h5
`define RST_PAGE_SEL     8'h00
`define RST_STATUS       6'h00
`define RST_FB_CTRL      8'h00
`define RST_IRQ_MASK     6'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DAMP_MSB         3
`define STAT_MSB         5
`define FB_EN_BIT        7
`define FB_SRC_MSB       5
`define FB_SRC_LSB       2
`define FB_LOOP_MSB      1
`define FB_LOOP_LSB      0
`define FB_SRC_MAX       4'hA

`endif

// File: core/loop_regs_pkg.sv
// Types shared by the loop status and feedback bank
package loop_regs_pkg;

    typedef enum logic [1:0]
    {
        SEL_LOOP_A   = 2'h0,
        SEL_LOOP_B   = 2'h1,
        SEL_LOOP_C   = 2'h2,
        SEL_RESERVED = 2'h3
    } loop_sel_type;

endpackage

// File: core/sticky_bits.sv
// Sticky flags set by hardware, cleared by write-one, set wins over clear
module sticky_bits
#(
    parameter int WIDTH = 6
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] flags;
    logic [WIDTH-1:0] next_flags;

    // ------------------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_flags = (flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flags <= '0;
        end
        else
        begin
            flags <= next_flags;
        end
    end

    assign q_o = flags;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_set_wins;
        @(posedge clk_i) disable iff (!rst_n_i)
        (set_i != '0) |=> ((flags & $past(set_i)) == $past(set_i));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost");

    property p_hold_unless_cleared;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clr_i == '0) |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_hold_unless_cleared: assert property (p_hold_unless_cleared) else $error("flag fell");

endmodule // sticky_bits

// File: core/fb_phase_calc.sv
// Feedback phase measurement by the selected loop and per-loop compensation
`include "loop_regs_defs.svh"
module fb_phase_calc
import loop_regs_pkg::*;
#(
    parameter int NREF = 11,
    parameter int PW   = 16
)
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     enable_i,
    input  wire logic [3:0]               src_i,
    input  wire loop_regs_pkg::loop_sel_type loop_i,
    input  wire logic [NREF*PW-1:0]       ref_phase_i,
    input  wire logic [11:0]              loop_ref_sel_i,
    input  wire logic [2:0]               loop_fb_en_i,
    output logic      [PW-1:0]            meas_o,
    output logic                          meas_valid_o,
    output logic      [3*PW-1:0]          corr_o
);
    import loop_regs_pkg::*;

    logic [PW-1:0]   meas;
    logic            valid;
    logic [3*PW-1:0] corr;
    logic [PW-1:0]   next_meas;
    logic            next_valid;
    logic [3*PW-1:0] next_corr;
    logic [3:0]      own_ref;
    logic            usable;

    function automatic logic [PW-1:0] pick(input logic [3:0] idx,
                                           input logic [NREF*PW-1:0] all);
        pick = '0;
        for (int k = 0; k < NREF; k++)
        begin
            if (idx == 4'(k))
            begin
                pick = all[k*PW +: PW];
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Measurement
    // ------------------------------------------------------------------------
    always_comb
    begin
        own_ref = loop_ref_sel_i[loop_i*4 +: 4];
        usable  = enable_i && (src_i <= `FB_SRC_MAX) && (loop_i != SEL_RESERVED);
        next_valid = usable;
        next_meas  = usable ? pick(own_ref, ref_phase_i) - pick(src_i, ref_phase_i)
                            : meas;
        for (int i = 0; i < 3; i++)
        begin
            next_corr[i*PW +: PW] = (loop_fb_en_i[i] && valid) ? meas : '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meas  <= '0;
            valid <= 1'b0;
            corr  <= '0;
        end
        else
        begin
            meas  <= next_meas;
            valid <= next_valid;
            corr  <= next_corr;
        end
    end

    assign meas_o       = meas;
    assign meas_valid_o = valid;
    assign corr_o       = corr;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_diff;
        @(posedge clk_i) disable iff (!rst_n_i)
        usable |=> valid && (meas == $past(pick(own_ref, ref_phase_i) - pick(src_i, ref_phase_i)));
    endproperty
    a_diff: assert property (p_diff) else $error("wrong phase difference");

    property p_src_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        (src_i > `FB_SRC_MAX) |=> !valid;
    endproperty
    a_src_reserved: assert property (p_src_reserved) else $error("reserved source used");

    property p_loop_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        (loop_i == SEL_RESERVED) |=> !valid;
    endproperty
    a_loop_reserved: assert property (p_loop_reserved) else $error("reserved loop used");

    property p_comp;
        @(posedge clk_i) disable iff (!rst_n_i)
        (loop_fb_en_i[2] && valid) |=> (corr[2*PW +: PW] == $past(meas));
    endproperty
    a_comp: assert property (p_comp) else $error("compensation missing");

    c_measure: cover property (@(posedge clk_i) disable iff (!rst_n_i) usable ##1 valid);

endmodule // fb_phase_calc

// File: core/loop_status_and_ext_feedback_regs.sv
// Loop lock/holdover sticky status and external feedback control registers
//
// Notes on behaviour
// - Lock of loop a, b, c sets status bit 1, 3, 5.
// - Holdover of loop a, b, c sets status bit 0, 2, 4.
// - Status bits stay high until software writes one to clear them.
// - Status bits set regardless of any mask register contents.
// - Feedback control bit 7 written to one enables external feedback.
// - Field 5:2 picks feedback reference 0 to 10; 11 to 15 reserved.
// - Field 1:0 picks measuring loop a, b, c; code 3 reserved.
// - Selected loop measures own reference phase minus feedback reference phase.
// - Each loop with its own feedback enable gets the measured phase correction.
`include "loop_regs_defs.svh"

module loop_status_and_ext_feedback_regs
#(
    parameter int NREF = 11,
    parameter int PW   = 16
)
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [11:0]                 addr_i,
    input  wire logic [7:0]                  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [7:0]                  rdata_o,
    input  wire logic [2:0]                  loop_locked_i,
    input  wire logic [2:0]                  loop_holdover_i,
    input  wire logic [NREF*PW-1:0]          ref_phase_i,
    input  wire logic [11:0]                 loop_ref_sel_i,
    input  wire logic [2:0]                  loop_fb_en_i,
    output logic      [3:0]                  damping_factor_o,
    output logic      [7:0]                  page_sel_o,
    output logic                             fb_enable_o,
    output logic      [3:0]                  fb_source_o,
    output loop_regs_pkg::loop_sel_type      fb_loop_o,
    output logic      [PW-1:0]               fb_phase_o,
    output logic                             fb_phase_valid_o,
    output logic      [3*PW-1:0]             phase_corr_o,
    output logic                             irq_o
);
    import loop_regs_pkg::*;

    logic [3:0]   damping;
    logic [7:0]   page_sel;
    logic [7:0]   fb_ctrl;
    logic [5:0]   irq_mask;
    logic [7:0]   rdata;
    logic [3:0]   next_damping;
    logic [7:0]   next_page_sel;
    logic [7:0]   next_fb_ctrl;
    logic [5:0]   next_irq_mask;
    logic [7:0]   next_rdata;
    logic [5:0]   status;
    logic [5:0]   status_set;
    logic [5:0]   status_clr;
    loop_sel_type fb_loop;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------------
    // Sticky status
    // ------------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            status_set[2*i+1] = loop_locked_i[i];
            status_set[2*i]   = loop_holdover_i[i];
        end
        status_clr = (wr_i && hit(addr_i, `OFF_STATUS)) ? wdata_i[`STAT_MSB:0] : 6'h00;
    end

    // Mask plays no part in setting, only in the interrupt
    sticky_bits
    #(
        .WIDTH (6)
    )
    u_status
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .set_i   (status_set),
        .clr_i   (status_clr),
        .q_o     (status)
    );

    // ------------------------------------------------------------------------
    // Register writes and read data
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_damping  = damping;
        next_page_sel = page_sel;
        next_fb_ctrl  = fb_ctrl;
        next_irq_mask = irq_mask;
        next_rdata    = 8'h00;
        if (wr_i)
        begin
            if (hit(addr_i, `OFF_DAMPING))
            begin
                next_damping = wdata_i[`DAMP_MSB:0];
            end
            if (hit(addr_i, `OFF_PAGE_SEL))
            begin
                next_page_sel = wdata_i;
            end
            if (hit(addr_i, `OFF_FB_CTRL))
            begin
                next_fb_ctrl = wdata_i & 8'hBF;
            end
            if (hit(addr_i, `OFF_IRQ_MASK))
            begin
                next_irq_mask = wdata_i[`STAT_MSB:0];
            end
        end
        if (rd_i)
        begin
            case (addr_i)
                `OFF_DAMPING:  next_rdata = {4'h0, damping};
                `OFF_PAGE_SEL: next_rdata = page_sel;
                `OFF_STATUS:   next_rdata = {2'h0, status};
                `OFF_FB_CTRL:  next_rdata = fb_ctrl;
                `OFF_IRQ_MASK: next_rdata = {2'h0, irq_mask};
                default:       next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            damping  <= `RST_DAMPING;
            page_sel <= `RST_PAGE_SEL;
            fb_ctrl  <= `RST_FB_CTRL;
            irq_mask <= `RST_IRQ_MASK;
            rdata    <= 8'h00;
        end
        else
        begin
            damping  <= next_damping;
            page_sel <= next_page_sel;
            fb_ctrl  <= next_fb_ctrl;
            irq_mask <= next_irq_mask;
            rdata    <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Feedback control fields
    // ------------------------------------------------------------------------
    // Setup order is left to software: enable is honoured as soon as written
    assign fb_loop          = loop_sel_type'(fb_ctrl[`FB_LOOP_MSB:`FB_LOOP_LSB]);
    assign fb_enable_o      = fb_ctrl[`FB_EN_BIT];
    assign fb_source_o      = fb_ctrl[`FB_SRC_MSB:`FB_SRC_LSB];
    assign fb_loop_o        = fb_loop;
    assign damping_factor_o = damping;
    assign page_sel_o       = page_sel;
    assign rdata_o          = rdata;
    assign irq_o            = |(status & irq_mask);

    fb_phase_calc
    #(
        .NREF (NREF),
        .PW   (PW)
    )
    u_fb
    (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .enable_i       (fb_ctrl[`FB_EN_BIT]),
        .src_i          (fb_ctrl[`FB_SRC_MSB:`FB_SRC_LSB]),
        .loop_i         (fb_loop),
        .ref_phase_i    (ref_phase_i),
        .loop_ref_sel_i (loop_ref_sel_i),
        .loop_fb_en_i   (loop_fb_en_i),
        .meas_o         (fb_phase_o),
        .meas_valid_o   (fb_phase_valid_o),
        .corr_o         (phase_corr_o)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_lock_a;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_locked_i[0] |=> status[1];
    endproperty
    a_lock_a: assert property (p_lock_a) else $error("lock a not flagged");

    property p_hold_b;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_holdover_i[1] |=> status[2];
    endproperty
    a_hold_b: assert property (p_hold_b) else $error("holdover b not flagged");

    property p_sticky;
        @(posedge clk_i) disable iff (!rst_n_i)
        ($rose(status[5]) && !loop_locked_i[2] && !(wr_i && hit(addr_i, `OFF_STATUS)))
            |=> status[5];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky bit dropped");

    property p_unmasked;
        @(posedge clk_i) disable iff (!rst_n_i)
        (irq_mask == 6'h00 && loop_locked_i[2]) |=> status[5];
    endproperty
    a_unmasked: assert property (p_unmasked) else $error("mask blocked status");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && hit(addr_i, `OFF_STATUS)) |=> (rdata_o[7:6] == 2'h0)
            && (rdata_o[5:0] == $past(status));
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("status read wrong");

    property p_enable;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_FB_CTRL)) |=> (fb_enable_o == $past(wdata_i[`FB_EN_BIT]));
    endproperty
    a_enable: assert property (p_enable) else $error("enable not taken");

    property p_source;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_FB_CTRL))
            |=> (fb_source_o == $past(wdata_i[`FB_SRC_MSB:`FB_SRC_LSB]));
    endproperty
    a_source: assert property (p_source) else $error("source not taken");

    property p_loop_sel;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_FB_CTRL) && wdata_i[`FB_EN_BIT] && wdata_i[1:0] == 2'h3)
            |=> ##1 !fb_phase_valid_o;
    endproperty
    a_loop_sel: assert property (p_loop_sel) else $error("reserved loop measured");

    property p_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        (loop_locked_i[1] && irq_mask[3] && !(wr_i && hit(addr_i, `OFF_IRQ_MASK))) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_lock_b;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_locked_i[1] |=> status[3];
    endproperty
    a_lock_b: assert property (p_lock_b) else $error("lock b not flagged");

    property p_lock_c;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_locked_i[2] |=> status[5];
    endproperty
    a_lock_c: assert property (p_lock_c) else $error("lock c not flagged");

    property p_hold_a;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_holdover_i[0] |=> status[0];
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("holdover a not flagged");

    property p_hold_c;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_holdover_i[2] |=> status[4];
    endproperty
    a_hold_c: assert property (p_hold_c) else $error("holdover c not flagged");

    property p_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_STATUS) && wdata_i[1] && !loop_locked_i[0]) |=> !status[1];
    endproperty
    a_clear: assert property (p_clear) else $error("status bit not cleared");

    property p_fb_bit6;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && hit(addr_i, `OFF_FB_CTRL)) |=> !rdata_o[6];
    endproperty
    a_fb_bit6: assert property (p_fb_bit6) else $error("reserved control bit read one");

    property p_rdata_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        !rd_i |=> (rdata_o == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

    property p_damp_store;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_DAMPING)) |=> (damping_factor_o == $past(wdata_i[`DAMP_MSB:0]));
    endproperty
    a_damp_store: assert property (p_damp_store) else $error("damping not stored");

    property p_page_store;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_PAGE_SEL)) |=> (page_sel_o == $past(wdata_i));
    endproperty
    a_page_store: assert property (p_page_store) else $error("page select not stored");

    c_lock_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        status[1] ##1 (wr_i && hit(addr_i, `OFF_STATUS) && wdata_i[1]) ##1 !status[1]);
    c_fb_on: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(fb_enable_o));
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
    c_set_wins: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, `OFF_STATUS) && wdata_i[5] && loop_locked_i[2]) ##1 status[5]);

endmodule // loop_status_and_ext_feedback_regs

// File: verif/tb_top.sv
// Self-checking testbench for the loop status and external feedback register bank
`include "loop_regs_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NREF    = 11;
    localparam int PW      = 16;
    localparam int CYC_MAX = 20000;

    logic                        clk_i;
    logic                        rst_n_i;
    logic                        wr_i;
    logic                        rd_i;
    logic [11:0]                 addr_i;
    logic [11:0]                 loop_ref_sel_i;
    logic [7:0]                  wdata_i;
    logic [7:0]                  rdata_o;
    logic [7:0]                  page_sel_o;
    logic [2:0]                  loop_locked_i;
    logic [2:0]                  loop_holdover_i;
    logic [2:0]                  loop_fb_en_i;
    logic [NREF*PW-1:0]          ref_phase_i;
    logic [3:0]                  damping_factor_o;
    logic [3:0]                  fb_source_o;
    logic                        fb_enable_o;
    logic                        fb_phase_valid_o;
    logic                        irq_o;
    loop_regs_pkg::loop_sel_type fb_loop_o;
    logic [PW-1:0]               fb_phase_o;
    logic [3*PW-1:0]             phase_corr_o;
    int                          error_cnt = 0;
    int                          n_checks  = 0;
    int                          cyc       = 0;
    logic                        rd_pend   = 1'b0;
    logic [7:0]                  exp_q[$];
    string                       nm_q[$];

    loop_status_and_ext_feedback_regs #(.NREF(NREF), .PW(PW)) uut
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .loop_locked_i(loop_locked_i),
        .loop_holdover_i(loop_holdover_i), .ref_phase_i(ref_phase_i),
        .loop_ref_sel_i(loop_ref_sel_i), .loop_fb_en_i(loop_fb_en_i),
        .damping_factor_o(damping_factor_o), .page_sel_o(page_sel_o),
        .fb_enable_o(fb_enable_o), .fb_source_o(fb_source_o), .fb_loop_o(fb_loop_o),
        .fb_phase_o(fb_phase_o), .fb_phase_valid_o(fb_phase_valid_o),
        .phase_corr_o(phase_corr_o), .irq_o(irq_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Read results are compared one cycle after the strobe is taken
    always @(negedge clk_i)
    begin
        if (rd_pend)
        begin
            if (exp_q.size() == 0)
                chk("read queue", 64'h1, 64'h0);
            else
                chk(nm_q.pop_front(), exp_q.pop_front(), rdata_o);
        end
        else if (rst_n_i)
            chk("rdata idle", 8'h00, rdata_o);
        rd_pend = rd_i & rst_n_i;
    end

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc >= CYC_MAX)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_i);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        addr_i  <= a;
        wdata_i <= 8'($urandom);
        wr_i    <= 1'b0;
        rd_i    <= 1'b1;
    endtask

    task automatic idle();
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic status_bit(input int b);
        logic [7:0] m;
        m = ((b >> 1) & 1) ? 8'h3F : 8'h00;
        wr(`OFF_IRQ_MASK, m);
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (b % 2)
            loop_locked_i[b/2] <= 1'b1;
        else
            loop_holdover_i[b/2] <= 1'b1;
        @(posedge clk_i);
        loop_locked_i   <= 3'h0;
        loop_holdover_i <= 3'h0;
        @(negedge clk_i);
        chk("irq_o set", m[b], irq_o);
        rd(`OFF_STATUS, 8'h01 << b, "status set");
        wr(`OFF_STATUS, 8'hC0 | (8'h01 << b));
        rd(`OFF_STATUS, 8'h00, "status cleared");
        idle();
        @(negedge clk_i);
        chk("irq_o cleared", 1'b0, irq_o);
    endtask

    task automatic fb_case(input logic [3:0] src, input logic [1:0] lp);
        logic [7:0]      cfg;
        logic [PW-1:0]   meas;
        logic [3*PW-1:0] corr;
        logic            valid;
        int              own;
        cfg = {2'b00, src, lp};
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        for (int k = 0; k < NREF; k++)
            ref_phase_i[k*PW +: PW] <= PW'($urandom);
        for (int i = 0; i < 3; i++)
            loop_ref_sel_i[i*4 +: 4] <= 4'($urandom_range(10));
        loop_fb_en_i <= 3'($urandom);
        wr(`OFF_FB_CTRL, cfg);
        wr(`OFF_FB_CTRL, cfg | 8'hC0);
        idle();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        valid = (src <= 4'hA) && (lp != 2'h3);
        meas  = '0;
        if (valid)
        begin
            own  = int'(loop_ref_sel_i[lp*4 +: 4]);
            meas = ref_phase_i[own*PW +: PW] - ref_phase_i[src*PW +: PW];
        end
        for (int i = 0; i < 3; i++)
            corr[i*PW +: PW] = (valid && loop_fb_en_i[i]) ? meas : '0;
        chk("fb_enable_o", 1'b1, fb_enable_o);
        chk("fb_source_o", src, fb_source_o);
        chk("fb_loop_o", lp, fb_loop_o);
        chk("fb_phase_valid_o", valid, fb_phase_valid_o);
        if (valid)
            chk("fb_phase_o", meas, fb_phase_o);
        chk("phase_corr_o", corr, phase_corr_o);
        rd(`OFF_FB_CTRL, cfg | 8'h80, "fb readback");
    endtask

    initial
    begin
        rst_n_i         = 1'b0;
        wr_i            = 1'b0;
        rd_i            = 1'b0;
        addr_i          = 12'h000;
        wdata_i         = 8'h00;
        loop_locked_i   = 3'h0;
        loop_holdover_i = 3'h0;
        loop_fb_en_i    = 3'h0;
        loop_ref_sel_i  = 12'h000;
        ref_phase_i     = '0;
        void'($urandom(32'h3EA673F4));
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values, storage and unmapped space
        rd(`OFF_DAMPING, 8'h05, "damping reset");
        rd(`OFF_PAGE_SEL, 8'h00, "page reset");
        rd(`OFF_STATUS, 8'h00, "status reset");
        rd(`OFF_FB_CTRL, 8'h00, "fb reset");
        rd(`OFF_IRQ_MASK, 8'h00, "mask reset");
        wr(`OFF_DAMPING, 8'hFF);
        wr(`OFF_PAGE_SEL, 8'hA5);
        wr(12'h100, 8'hFF);
        rd(`OFF_DAMPING, 8'h0F, "damping stored");
        rd(`OFF_PAGE_SEL, 8'hA5, "page stored");
        rd(12'h100, 8'h00, "unmapped");
        idle();
        @(negedge clk_i);
        chk("damping_factor_o", 4'hF, damping_factor_o);
        chk("page_sel_o", 8'hA5, page_sel_o);
        // Sticky status bits and interrupt
        for (int b = 0; b < 6; b++)
            status_bit(b);
        @(posedge clk_i);
        loop_locked_i <= 3'h4;
        wr(`OFF_STATUS, 8'h20);
        rd(`OFF_STATUS, 8'h20, "status set wins");
        idle();
        loop_locked_i <= 3'h0;
        wr(`OFF_STATUS, 8'h20);
        rd(`OFF_STATUS, 8'h00, "status cleared");
        // Every feedback source and loop code
        for (int s = 0; s < 16; s++)
            for (int l = 0; l < 4; l++)
                fb_case(4'(s), 2'(l));
        wr(`OFF_FB_CTRL, 8'h04);
        idle();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("fb_phase_valid_o off", 1'b0, fb_phase_valid_o);
        // Reset in mid-run
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(negedge clk_i);
        chk("damping after reset", 4'h5, damping_factor_o);
        chk("fb_enable after reset", 1'b0, fb_enable_o);
        chk("corr after reset", '0, phase_corr_o);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        report_and_stop();
    end
endmodule // tb_top
